// >>> verilog/btpg_pkg.sv
/*
 constants, types and helper functions of the burn-in test pattern generator.
 assumes a single 250 MHz clock and byte registers written over the serial control port.
*/
package btpg_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_TEST_MODE = 8'h1A;
    localparam logic [7:0] ADDR_LINE_WIDTH = 8'h1B;
    localparam logic [7:0] ADDR_COL_SPACING = 8'h1C;
    localparam logic [7:0] ADDR_ROW_SPACING = 8'h1D;
    localparam logic [7:0] ADDR_GRAY_LEVEL = 8'h1E;

    localparam logic [4:0] RST_TEST_MODE = 5'h00;
    localparam logic [7:0] RST_LINE_WIDTH = 8'h00;
    localparam logic [7:0] RST_COL_SPACING = 8'h00;
    localparam logic [7:0] RST_ROW_SPACING = 8'h00;
    localparam logic [7:0] RST_GRAY_LEVEL = 8'h07;

    localparam int MODE_CHOICE_LSB = 0;
    localparam int MODE_ENABLE_BIT = 3;
    localparam int MODE_CLK_SRC_BIT = 4;
    localparam int GRAY_FG_LSB = 0;
    localparam int GRAY_BG_LSB = 4;

    // ------------------------------------------------------------------
    // frame timing, counted in generator pixels
    // ------------------------------------------------------------------
    localparam logic [10:0] H_ACTIVE = 11'd1280;
    localparam logic [10:0] H_SYNC_START = 11'd1296;
    localparam logic [10:0] H_SYNC_END = 11'd1328;
    localparam logic [10:0] H_TOTAL = 11'd1344;
    localparam logic [10:0] V_ACTIVE = 11'd1024;
    localparam logic [10:0] V_SYNC_START = 11'd1028;
    localparam logic [10:0] V_SYNC_END = 11'd1031;
    localparam logic [10:0] V_TOTAL = 11'd1066;

    localparam logic [3:0] RING_DIV = 4'd4;
    localparam logic [2:0] RAMP_STEP = 3'd5;
    localparam int BAR_BIT = 7;
    localparam int CHECK_BIT = 6;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PAT_WHITE = 3'b000,
        PAT_BARS = 3'b001,
        PAT_RAMP = 3'b010,
        PAT_CHECKER = 3'b011,
        PAT_COLUMNS = 3'b100,
        PAT_ROWS = 3'b101,
        PAT_GRID = 3'b110,
        PAT_GRAY = 3'b111
    } btpg_pattern_t;

    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000,
        I2C_RECV = 3'b001,
        I2C_RACK = 3'b010,
        I2C_SEND = 3'b011,
        I2C_MACK = 3'b100
    } btpg_i2c_state_t;

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    // three-bit colour code (r,g,b) to full-scale components
    function automatic logic [23:0] btpg_expand(input logic [2:0] code);
        btpg_expand = {{8{code[2]}}, {8{code[1]}}, {8{code[0]}}};
    endfunction : btpg_expand

    // stripe phase counter: period is (width+1)+(gap+1)
    function automatic logic [8:0] btpg_next_phase(input logic [8:0] cnt,
                                                   input logic [7:0] width,
                                                   input logic [7:0] gap);
        logic [8:0] last;
        last = {1'b0, width} + {1'b0, gap} + 9'h001;
        btpg_next_phase = (cnt == last) ? 9'h000 : cnt + 9'h001;
    endfunction : btpg_next_phase

endpackage : btpg_pkg

// >>> verilog/btpg_i2c_slave.sv
/*
 serial control port: byte-wide register access over a two-wire bus.
 assumes scl and sda arrive asynchronously; the wire level is resolved outside.
*/
`timescale 1ns/1ps
module btpg_i2c_slave #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary value
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_we,
    input wire logic [7:0] reg_rdata
);
    import btpg_pkg::*;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_l;
        logic sda_l;
        btpg_i2c_state_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [1:0] kind;
        logic rw;
        logic nack;
        logic [7:0] ptr;
        logic [7:0] wdata;
        logic we;
        logic oe;
    } btpg_i2c_t;

    btpg_i2c_t r;
    btpg_i2c_t next_r;

    // ------------------------------------------------------------------
    // bus engine
    // ------------------------------------------------------------------
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c = 1'b0;
        stop_c = 1'b0;
        next_r = r;
        next_r.we = 1'b0;
        next_r.scl_s = {r.scl_s[1:0], scl_in};
        next_r.sda_s = {r.sda_s[1:0], sda_in};
        if (r.scl_s[1] == r.scl_s[2]) begin
            next_r.scl_l = r.scl_s[2];
        end
        if (r.sda_s[1] == r.sda_s[2]) begin
            next_r.sda_l = r.sda_s[2];
        end
        scl_rise = next_r.scl_l & ~r.scl_l;
        scl_fall = ~next_r.scl_l & r.scl_l;
        start_c = r.scl_l & next_r.scl_l & r.sda_l & ~next_r.sda_l;
        stop_c = r.scl_l & next_r.scl_l & ~r.sda_l & next_r.sda_l;
        if (start_c) begin
            next_r.st = I2C_RECV;
            next_r.cnt = 4'd0;
            next_r.kind = 2'd0;
            next_r.oe = 1'b0;
        end else if (stop_c) begin
            next_r.st = I2C_IDLE;
            next_r.oe = 1'b0;
        end else begin
            case (r.st)
                I2C_RECV: begin
                    if (scl_rise && r.cnt != 4'd8) begin
                        next_r.sh = {r.sh[6:0], next_r.sda_l};
                        next_r.cnt = r.cnt + 4'd1;
                    end else if (scl_fall && r.cnt == 4'd8) begin
                        next_r.st = I2C_RACK;
                        next_r.oe = 1'b1;
                        if (r.kind == 2'd0) begin
                            next_r.rw = r.sh[0];
                            if (r.sh[7:1] != DEV_ADDR) begin
                                next_r.st = I2C_IDLE;
                                next_r.oe = 1'b0;
                            end
                        end else if (r.kind == 2'd1) begin
                            next_r.ptr = r.sh;
                        end else begin
                            next_r.we = 1'b1;
                            next_r.wdata = r.sh;
                        end
                    end
                end
                I2C_RACK: begin
                    if (scl_fall) begin
                        next_r.oe = 1'b0;
                        next_r.cnt = 4'd0;
                        if (r.we || r.kind == 2'd2) begin
                            next_r.ptr = r.ptr + 8'h01;
                        end
                        if (r.kind == 2'd0 && r.rw) begin
                            next_r.st = I2C_SEND;
                            next_r.sh = reg_rdata;
                            next_r.oe = ~reg_rdata[7];
                            next_r.cnt = 4'd1;
                        end else begin
                            next_r.st = I2C_RECV;
                            next_r.kind = (r.kind == 2'd0) ? 2'd1 : 2'd2;
                        end
                    end
                end
                I2C_SEND: begin
                    if (scl_fall) begin
                        if (r.cnt == 4'd8) begin
                            next_r.oe = 1'b0;
                            next_r.st = I2C_MACK;
                            next_r.ptr = r.ptr + 8'h01;
                        end else begin
                            next_r.sh = {r.sh[6:0], 1'b1};
                            next_r.oe = ~r.sh[6];
                            next_r.cnt = r.cnt + 4'd1;
                        end
                    end
                end
                I2C_MACK: begin
                    if (scl_rise) begin
                        next_r.nack = next_r.sda_l;
                    end else if (scl_fall) begin
                        if (r.nack) begin
                            next_r.st = I2C_IDLE;
                        end else begin
                            next_r.st = I2C_SEND;
                            next_r.sh = reg_rdata;
                            next_r.oe = ~reg_rdata[7];
                            next_r.cnt = 4'd1;
                        end
                    end
                end
                default: begin
                    next_r.oe = 1'b0;
                end
            endcase
        end
        if (!reset_n) begin
            next_r = '0;
            next_r.scl_s = 3'b111;
            next_r.sda_s = 3'b111;
            next_r.scl_l = 1'b1;
            next_r.sda_l = 1'b1;
            next_r.st = I2C_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        r <= next_r;
    end

    assign sda_out = 1'b0;
    assign sda_oe = r.oe;
    assign reg_addr = r.ptr;
    assign reg_wdata = r.wdata;
    assign reg_we = r.we;

endmodule : btpg_i2c_slave

// >>> verilog/btpg_top.sv
/*
 burn-in test pattern generator with its byte registers and serial control port.
 assumes burnin_pin and lvds_clk are asynchronous pins and the display samples
 pixel data while pix_clk is high.
*/
`timescale 1ns/1ps
module btpg_top #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary value
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic burnin_pin,
    input wire logic lvds_clk,
    output logic test_active,
    output logic pix_clk,
    output logic hsync,
    output logic vsync,
    output logic data_enable,
    output logic [7:0] pix_red,
    output logic [7:0] pix_green,
    output logic [7:0] pix_blue
);
    import btpg_pkg::*;

    typedef struct packed {
        logic [4:0] test_mode_control;
        logic [7:0] pattern_line_width;
        logic [7:0] pattern_column_spacing;
        logic [7:0] pattern_row_spacing;
        logic [7:0] pattern_gray_level;
        logic [2:0] bi_s;
        logic bi_l;
        logic [2:0] lc_s;
        logic lc_l;
        logic [3:0] ring_cnt;
        logic [10:0] h_cnt;
        logic [10:0] v_cnt;
        logic [8:0] col_ph;
        logic [8:0] row_ph;
        logic [2:0] ramp_sub;
        logic [7:0] ramp_val;
        logic pclk;
        logic hs;
        logic vs;
        logic de;
        logic [23:0] rgb;
    } btpg_state_t;

    btpg_state_t r;
    btpg_state_t next_r;

    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_we;
    logic [7:0] reg_rdata;

    // ------------------------------------------------------------------
    // serial control port
    // ------------------------------------------------------------------
    btpg_i2c_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_i2c (
        .mclk(mclk),
        .reset_n(reset_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_we(reg_we),
        .reg_rdata(reg_rdata)
    );

    // ------------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            ADDR_TEST_MODE: reg_rdata = {3'b000, r.test_mode_control};
            ADDR_LINE_WIDTH: reg_rdata = r.pattern_line_width;
            ADDR_COL_SPACING: reg_rdata = r.pattern_column_spacing;
            ADDR_ROW_SPACING: reg_rdata = r.pattern_row_spacing;
            ADDR_GRAY_LEVEL: reg_rdata = r.pattern_gray_level;
            default: reg_rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // generator
    // ------------------------------------------------------------------
    always_comb begin
        logic active;
        logic pix_en;
        logic col_on;
        logic row_on;
        logic [2:0] choice;
        logic [23:0] fg;
        logic [23:0] bg;
        logic [23:0] px;
        logic vis;
        active = 1'b0;
        pix_en = 1'b0;
        col_on = 1'b0;
        row_on = 1'b0;
        choice = 3'b000;
        fg = 24'h000000;
        bg = 24'h000000;
        px = 24'h000000;
        vis = 1'b0;
        next_r = r;
        next_r.pclk = 1'b0;

        // register writes
        if (reg_we) begin
            case (reg_addr)
                ADDR_TEST_MODE: next_r.test_mode_control = reg_wdata[4:0];
                ADDR_LINE_WIDTH: next_r.pattern_line_width = reg_wdata;
                ADDR_COL_SPACING: next_r.pattern_column_spacing = reg_wdata;
                ADDR_ROW_SPACING: next_r.pattern_row_spacing = reg_wdata;
                ADDR_GRAY_LEVEL: next_r.pattern_gray_level = reg_wdata;
                default: next_r.pattern_gray_level = r.pattern_gray_level;
            endcase
        end

        // pin synchronisers, level changes once stages two and three agree
        next_r.bi_s = {r.bi_s[1:0], burnin_pin};
        next_r.lc_s = {r.lc_s[1:0], lvds_clk};
        if (r.bi_s[1] == r.bi_s[2]) begin
            next_r.bi_l = r.bi_s[2];
        end
        if (r.lc_s[1] == r.lc_s[2]) begin
            next_r.lc_l = r.lc_s[2];
        end

        active = r.bi_l | r.test_mode_control[MODE_ENABLE_BIT];

        if (r.test_mode_control[MODE_CLK_SRC_BIT]) begin
            pix_en = next_r.lc_l & ~r.lc_l;
            next_r.ring_cnt = 4'd0;
        end else begin
            pix_en = (r.ring_cnt == RING_DIV - 4'd1);
            next_r.ring_cnt = pix_en ? 4'd0 : r.ring_cnt + 4'd1;
        end

        col_on = (r.col_ph <= {1'b0, r.pattern_line_width});
        row_on = (r.row_ph <= {1'b0, r.pattern_line_width});

        fg = btpg_expand(r.pattern_gray_level[GRAY_FG_LSB +: 3]);
        bg = btpg_expand(r.pattern_gray_level[GRAY_BG_LSB +: 3]);
        choice = r.test_mode_control[MODE_CHOICE_LSB +: 3];
        vis = (r.h_cnt < H_ACTIVE) && (r.v_cnt < V_ACTIVE);

        case (choice)
            PAT_WHITE: px = 24'hFFFFFF;
            PAT_BARS: px = btpg_expand({3{~r.h_cnt[BAR_BIT]}});
            PAT_RAMP: px = {3{r.ramp_val}};
            PAT_CHECKER: px = btpg_expand({3{~(r.h_cnt[CHECK_BIT] ^ r.v_cnt[CHECK_BIT])}});
            // columns use width and column gap
            PAT_COLUMNS: px = col_on ? fg : bg;
            // rows use width and row gap
            PAT_ROWS: px = row_on ? fg : bg;
            PAT_GRID: px = (col_on || row_on) ? fg : bg;
            PAT_GRAY: px = {3{r.pattern_gray_level}};
            default: px = 24'hFFFFFF;
        endcase

        if (!active) begin
            next_r.h_cnt = 11'd0;
            next_r.v_cnt = 11'd0;
            next_r.col_ph = 9'h000;
            next_r.row_ph = 9'h000;
            next_r.ramp_sub = 3'd0;
            next_r.ramp_val = 8'h00;
            next_r.hs = 1'b0;
            next_r.vs = 1'b0;
            next_r.de = 1'b0;
            next_r.rgb = 24'h000000;
        end else if (pix_en) begin
            // own pixel clock, syncs and data
            next_r.pclk = 1'b1;
            next_r.de = vis;
            next_r.rgb = vis ? px : 24'h000000;
            next_r.hs = (r.h_cnt >= H_SYNC_START) && (r.h_cnt < H_SYNC_END);
            next_r.vs = (r.v_cnt >= V_SYNC_START) && (r.v_cnt < V_SYNC_END);
            // stripes restart from the first pixel
            if (r.h_cnt == H_TOTAL - 11'd1) begin
                next_r.h_cnt = 11'd0;
                next_r.col_ph = 9'h000;
                next_r.ramp_sub = 3'd0;
                next_r.ramp_val = 8'h00;
                if (r.v_cnt == V_TOTAL - 11'd1) begin
                    next_r.v_cnt = 11'd0;
                    next_r.row_ph = 9'h000;
                end else begin
                    next_r.v_cnt = r.v_cnt + 11'd1;
                    next_r.row_ph = btpg_next_phase(r.row_ph, r.pattern_line_width,
                                                    r.pattern_row_spacing);
                end
            end else begin
                next_r.h_cnt = r.h_cnt + 11'd1;
                next_r.col_ph = btpg_next_phase(r.col_ph, r.pattern_line_width,
                                                r.pattern_column_spacing);
                if (r.ramp_sub == RAMP_STEP - 3'd1) begin
                    next_r.ramp_sub = 3'd0;
                    next_r.ramp_val = r.ramp_val + 8'h01;
                end else begin
                    next_r.ramp_sub = r.ramp_sub + 3'd1;
                end
            end
        end

        if (!reset_n) begin
            next_r = '0;
            next_r.test_mode_control = RST_TEST_MODE;
            next_r.pattern_line_width = RST_LINE_WIDTH;
            next_r.pattern_column_spacing = RST_COL_SPACING;
            next_r.pattern_row_spacing = RST_ROW_SPACING;
            next_r.pattern_gray_level = RST_GRAY_LEVEL;
        end
    end

    always_ff @(posedge mclk) begin
        r <= next_r;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign test_active = r.bi_l | r.test_mode_control[MODE_ENABLE_BIT];
    assign pix_clk = r.pclk;
    assign hsync = r.hs;
    assign vsync = r.vs;
    assign data_enable = r.de;
    assign pix_red = r.rgb[23:16];
    assign pix_green = r.rgb[15:8];
    assign pix_blue = r.rgb[7:0];

endmodule : btpg_top

// >>> bench/btpg_monitor.sv
/*
 port checker for the burn-in pattern generator.
 assumes ring divider 4 and an lvds clock of ten mclk periods.
*/
`timescale 1ns/1ps
module btpg_monitor (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic sda_out,
    input wire logic burnin_pin,
    input wire logic test_active,
    input wire logic pix_clk,
    input wire logic hsync,
    input wire logic data_enable,
    input wire logic [7:0] pix_red
);
    // ----------------------------
    // visible run per line
    // ----------------------------
    logic [10:0] de_run;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    always_ff @(posedge mclk) begin
        if (!reset_n || !test_active) begin
            de_run <= 11'h000;
        end else if (pix_clk) begin
            de_run <= data_enable ? de_run + 11'h001 : 11'h000;
        end
    end
    pulse_gap_a: assert property (pix_clk |=> !pix_clk [*3])
        else $error("pixel pulses too close");
    pulse_period_a: assert property (
        pix_clk && test_active |=> ##[2:20] (pix_clk || !test_active))
        else $error("pixel pulse missing");
    idle_quiet_a: assert property (
        !test_active ##1 !test_active |-> !data_enable && !hsync && pix_red == 8'h00)
        else $error("output while idle");
    hold_between_a: assert property (
        test_active && $past(test_active) && !pix_clk
        |-> $stable(data_enable) && $stable(hsync) && $stable(pix_red))
        else $error("output moved between pulses");
    sync_apart_a: assert property (!(hsync && data_enable))
        else $error("sync inside visible area");
    line_len_a: assert property (
        pix_clk && !data_enable && de_run != 11'h000 |-> de_run == 11'h500)
        else $error("visible line length wrong");
    open_drain_a: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    burnin_force_a: assert property (burnin_pin [*8] |=> test_active)
        else $error("pin did not start test");
endmodule : btpg_monitor
bind btpg_top btpg_monitor btpg_monitor_inst (.mclk(mclk), .reset_n(reset_n),
    .sda_out(sda_out), .burnin_pin(burnin_pin), .test_active(test_active),
    .pix_clk(pix_clk), .hsync(hsync), .data_enable(data_enable), .pix_red(pix_red));

// >>> bench/btpg_display_model.sv
/*
 display-side model: follows the raster and keeps the last sampled pixel, with cap_valid set if it was visible.
 assumes the first pulse after activation is the top-left pixel.
*/
`timescale 1ns/1ps
module btpg_display_model (
    input wire logic mclk,
    input wire logic test_active,
    input wire logic pix_clk,
    input wire logic hsync,
    input wire logic vsync,
    input wire logic data_enable,
    input wire logic [23:0] pix_rgb,
    output logic [10:0] cap_h,
    output logic [10:0] cap_v,
    output logic cap_valid,
    output logic [23:0] cap_rgb,
    output logic frame_err
);
    import btpg_pkg::*;
    logic [10:0] nh;
    logic [10:0] nv;
    initial frame_err = 1'b0;
    always @(posedge mclk) begin
        if (test_active !== 1'b1) begin
            nh <= 11'h000;
            nv <= 11'h000;
            cap_valid <= 1'b0;
        end else if (pix_clk === 1'b1) begin
            cap_h <= nh;
            cap_v <= nv;
            cap_valid <= data_enable;
            cap_rgb <= pix_rgb;
            if (data_enable !== (nh < H_ACTIVE && nv < V_ACTIVE)
                || vsync !== (nv >= V_SYNC_START && nv < V_SYNC_END)
                || hsync !== (nh >= H_SYNC_START && nh < H_SYNC_END)) begin
                frame_err <= 1'b1;
            end
            nh <= (nh == H_TOTAL - 11'h001) ? 11'h000 : nh + 11'h001;
            if (nh == H_TOTAL - 11'h001) begin
                nv <= nv + 11'h001;
            end
        end
    end
endmodule : btpg_display_model

// >>> bench/btpg_top_test.sv
/*
 self-checking bench for the burn-in pattern generator.
 assumes the default device address and a 250 MHz mclk.
*/
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR %0t got %h expected %h", $time, (got), (exp)); end end
module btpg_top_test;
    import btpg_pkg::*;
    localparam logic [6:0] DEV = 7'h2A;
    localparam logic [7:0] GRAY = 8'h52;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic scl_m = 1'b1;
    logic sda_m = 1'b1;
    logic burnin_pin = 1'b0;
    logic lvds_clk = 1'b0;
    logic lvds_run = 1'b0;
    logic sda_out, sda_oe, sda_w, test_active, pix_clk, hsync, vsync, data_enable;
    logic [7:0] pix_red, pix_green, pix_blue;
    logic [10:0] cap_h, cap_v;
    logic cap_valid, frame_err;
    logic [23:0] cap_rgb;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    int xs [6] = '{64, 66, 70, 130, 1, 3};
    int ys [6] = '{0, 0, 0, 0, 1, 1};
    assign sda_w = sda_m && !(sda_oe && !sda_out);
    always #2 mclk = ~mclk;
    always #20 lvds_clk = lvds_run ? ~lvds_clk : lvds_clk;
    btpg_top btpg_top_inst (.mclk(mclk), .reset_n(reset_n), .scl_in(scl_m), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .burnin_pin(burnin_pin), .lvds_clk(lvds_clk),
        .test_active(test_active), .pix_clk(pix_clk), .hsync(hsync), .vsync(vsync),
        .data_enable(data_enable), .pix_red(pix_red), .pix_green(pix_green),
        .pix_blue(pix_blue));
    btpg_display_model btpg_display_model_inst (.mclk(mclk), .test_active(test_active),
        .pix_clk(pix_clk), .hsync(hsync), .vsync(vsync), .data_enable(data_enable),
        .pix_rgb({pix_red, pix_green, pix_blue}), .cap_h(cap_h), .cap_v(cap_v),
        .cap_valid(cap_valid), .cap_rgb(cap_rgb), .frame_err(frame_err));
    // ----------------------------
    // bus tasks and scenarios
    // ----------------------------
    task automatic finish_test();
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 95000) begin
            miscompares++;
            $display("ERROR %0t timeout", $time);
            finish_test();
        end
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
    endtask : wait_clk
    task automatic i2c_bit(input logic b, output logic r);
        sda_m <= b;
        wait_clk(9);
        scl_m <= 1'b1;
        wait_clk(9);
        r = sda_w;
        scl_m <= 1'b0;
        wait_clk(3);
    endtask : i2c_bit
    task automatic i2c_start();
        sda_m <= 1'b1;
        wait_clk(9);
        scl_m <= 1'b1;
        wait_clk(9);
        sda_m <= 1'b0;
        wait_clk(9);
        scl_m <= 1'b0;
        wait_clk(3);
    endtask : i2c_start
    task automatic wbyte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) i2c_bit(b[i], r);
        i2c_bit(1'b1, r);
        `CHECK(r, 1'b0)
    endtask : wbyte
    task automatic reg_acc(input logic rd, input logic [7:0] a, input logic [7:0] wd,
                           output logic [7:0] q);
        logic r;
        i2c_start();
        wbyte({DEV, 1'b0});
        wbyte(a);
        if (rd) begin
            i2c_start();
            wbyte({DEV, 1'b1});
            for (int i = 7; i >= 0; i--) i2c_bit(1'b1, q[i]);
            i2c_bit(1'b1, r);
        end else begin
            wbyte(wd);
        end
        sda_m <= 1'b0;
        wait_clk(9);
        scl_m <= 1'b1;
        wait_clk(9);
        sda_m <= 1'b1;
        wait_clk(9);
    endtask : reg_acc
    task automatic get_px(input int x, input int y, output logic [23:0] rgb);
        int k;
        k = 0;
        while (!(cap_valid === 1'b1 && cap_h == 11'(x) && cap_v == 11'(y)) && k < 30000) begin
            @(posedge mclk);
            k++;
        end
        rgb = (k < 30000) ? cap_rgb : 24'hX;
    endtask : get_px
    task automatic pulse_gap(output int g);
        g = 0;
        while (pix_clk !== 1'b1 && g < 40) begin
            @(posedge mclk);
            g++;
        end
        g = 0;
        do begin
            @(posedge mclk);
            g++;
        end while (pix_clk !== 1'b1 && g < 40);
    endtask : pulse_gap
    function automatic logic [23:0] col3(input logic [2:0] c);
        return {{8{c[2]}}, {8{c[1]}}, {8{c[0]}}};
    endfunction : col3
    // width 1 with column gap 2 and row gap 1
    function automatic logic [23:0] exp_px(input int c, input int x, input int y);
        logic cf, rf;
        cf = (x % 3) == 0;
        rf = (y % 2) == 0;
        case (c)
            0: return 24'hFFFFFF;
            1: return x[7] ? 24'h000000 : 24'hFFFFFF;
            2: return {3{8'(x / 5)}};
            3: return (x[6] ^ y[6]) ? 24'h000000 : 24'hFFFFFF;
            4: return col3(cf ? GRAY[2:0] : GRAY[6:4]);
            5: return col3(rf ? GRAY[2:0] : GRAY[6:4]);
            6: return col3((cf || rf) ? GRAY[2:0] : GRAY[6:4]);
            default: return {3{GRAY}};
        endcase
    endfunction : exp_px
    task automatic test_regs();
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            reg_acc(1'b1, 8'h1A + 8'(i), 8'h00, d);
            `CHECK(d, (i == 4) ? 8'h07 : 8'h00)
        end
        reg_acc(1'b0, 8'h1F, 8'h55, d);
        reg_acc(1'b1, 8'h1F, 8'h00, d);
        `CHECK(d, 8'h00)
        reg_acc(1'b0, 8'h1A, 8'hE0, d);
        reg_acc(1'b1, 8'h1A, 8'h00, d);
        `CHECK(d, 8'h00)
        `CHECK(test_active, 1'b0)
    endtask : test_regs
    task automatic test_burnin();
        logic [23:0] px;
        int g;
        burnin_pin <= 1'b1;
        get_px(2, 0, px);
        `CHECK(px, 24'hFFFFFF)
        pulse_gap(g);
        `CHECK(g, int'(RING_DIV))
        burnin_pin <= 1'b0;
        wait_clk(20);
        `CHECK(test_active, 1'b0)
    endtask : test_burnin
    task automatic test_patterns();
        logic [7:0] d;
        logic [23:0] px;
        logic [7:0] prm [4] = '{8'h00, 8'h01, 8'h00, GRAY};
        for (int i = 0; i < 4; i++) reg_acc(1'b0, 8'h1B + 8'(i), prm[i], d);
        reg_acc(1'b1, 8'h1C, 8'h00, d);
        `CHECK(d, 8'h01)
        for (int c = 0; c < 8; c++) begin
            reg_acc(1'b0, 8'h1A, 8'h00, d);
            reg_acc(1'b0, 8'h1A, 8'h08 | 8'(c), d);
            for (int s = 0; s < 6; s++) begin
                get_px(xs[s], ys[s], px);
                `CHECK(px, exp_px(c, xs[s], ys[s]))
            end
        end
    endtask : test_patterns
    task automatic test_lvds();
        logic [7:0] d;
        logic [23:0] px;
        int g;
        reg_acc(1'b0, 8'h1A, 8'h00, d);
        lvds_run <= 1'b1;
        reg_acc(1'b0, 8'h1A, 8'h18, d);
        get_px(20, 0, px);
        `CHECK(px, 24'hFFFFFF)
        pulse_gap(g);
        `CHECK(g, 10)
        reg_acc(1'b0, 8'h1A, 8'h00, d);
        lvds_run <= 1'b0;
    endtask : test_lvds
    initial begin
        wait_clk(12);
        reset_n <= 1'b1;
        wait_clk(4);
        test_regs();
        test_burnin();
        test_patterns();
        test_lvds();
        `CHECK(frame_err, 1'b0)
        finish_test();
    end
endmodule : btpg_top_test
